// *** design/uotg_map.svh ***
// Register offsets, field positions, reset values and timing counts of the OTG control slice.
// Included by the design module only; definitions only.
`ifndef UOTG_MAP_SVH
`define UOTG_MAP_SVH

`define UOTG_OFS_TOKEN      12'h000
`define UOTG_OFS_THRESH     12'h004
`define UOTG_OFS_CFG1       12'h008
`define UOTG_OFS_CFG2       12'h00c
`define UOTG_OFS_FLAGS      12'h010
`define UOTG_OFS_FLAG_EN    12'h014
`define UOTG_OFS_POWER      12'h018
`define UOTG_OFS_LIVE       12'h01c

`define UOTG_TOK_TYPE_HI    7
`define UOTG_TOK_TYPE_LO    4
`define UOTG_TOK_EP_HI      3
`define UOTG_TOK_EP_LO      0

`define UOTG_CFG1_EYE       7
`define UOTG_CFG1_MON       6
`define UOTG_CFG1_IDLE      4
`define UOTG_CFG1_MASK      8'hd3
`define UOTG_CFG2_MASK      8'h3f
`define UOTG_CFG2_CMPSEL    5
`define UOTG_CFG2_PULLUP    4
`define UOTG_CFG2_I2C       3
`define UOTG_CFG2_BOOST     2
`define UOTG_CFG2_CMPDIS    1
`define UOTG_CFG2_XCVR      0
`define UOTG_FLAG_MASK      8'hfd
`define UOTG_FLAG_ID        7
`define UOTG_FLAG_MS        6
`define UOTG_FLAG_LINE      5
`define UOTG_FLAG_ACT       4
`define UOTG_FLAG_SESV      3
`define UOTG_FLAG_SEND      2
`define UOTG_FLAG_VBUS      0

`define UOTG_RESET_BYTE     8'h00
`define UOTG_THRESH_EXTRA   8'h0a

`define UOTG_MS_NS          1000000
`define UOTG_CLK_NS         8
`define UOTG_MS_CYCLES      (`UOTG_MS_NS / `UOTG_CLK_NS)

`endif

// *** design/uotg_pkg.sv ***
// Types shared by the OTG control slice.
// Needs no include path; the design module includes uotg_map.svh.
package uotg_pkg;
  typedef enum logic [3:0] {
    TOK_OUT   = 4'h1,
    TOK_IN    = 4'h9,
    TOK_SETUP = 4'hd
  } uotg_token_type;

  typedef enum logic [1:0] {
    PP_OFF     = 2'h0,
    PP_EP0_OUT = 2'h1,
    PP_ALL     = 2'h2,
    PP_EP1_15  = 2'h3
  } uotg_pingpong_type;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WR   = 3'b010,
    BUS_RD   = 3'b100
  } uotg_bus_state_type;
endpackage : uotg_pkg

// *** design/uotg_ctrl.sv ***
// OTG host token, frame threshold, configuration and event flag registers behind an AHB-Lite slave.
// Assumes pins from the bus side arrive asynchronously; AHB signals run on ref_clk.
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`include "uotg_map.svh"

// Functional notes
// (R01) Token type 1101 SETUP, 1001 IN, 0001 OUT starts a host transaction.
// (R02) Software writes only the three defined token type codes.
// (R03) Software puts a real endpoint number in the low token nibble.
// (R04) Frame threshold holds packet bytes plus ten.
// (R05) Bits 15..8 and unused bits read zero.
// (R06) Config one bit 7 enables eye pattern test.
// (R07) Monitor bit drives active-low output enable while lines are driven.
// (R08) Monitor only acts when transceiver disable is set.
// (R09) Halt-in-idle stops the module while processor is idle.
// (R10) Two-bit ping-pong field selects even/odd buffering scope.
// (R11) Comparator select picks three separate pins or two encoded pins.
// (R12) VBUS pull-up follows its enable bit.
// (R13) External control via I2C when set, dedicated pins when clear.
// (R14) Boost disable turns on digital supply control output.
// (R15) Comparator disable turns on digital comparator input interface.
// (R16) Transceiver disable routes lines to external transceiver.
// (R17) Software leaves the three disable bits alone while powered.
// (R18) ID pin change sets the ID flag.
// (R19) One millisecond timer expiry sets the timer flag.
// (R20) Line state stable 1 ms and changed sets the line flag.
// (R21) Any D+/D- or VBUS activity sets the activity flag.
// (R22) VBUS threshold crossings either way set session and valid flags.
// (R23) Flags set by hardware, cleared by writing one.
// (R24) Power enable bit 0 switches the module on.
// (R25) Idle level flag shows J state per speed.
// (R26) Each flag has its own enable bit.
// (R27) Interrupt output high while any enabled flag is set.
module uotg_ctrl #(
  parameter int MS_CYCLES = `UOTG_MS_CYCLES
) (
  input  wire logic        ref_clk,            // System clock, 125 MHz
  input  wire logic        rst_n,              // Async reset, active low
  input  wire logic        hsel,               // AHB slave select
  input  wire logic [11:0] haddr,              // AHB address
  input  wire logic [1:0]  htrans,             // AHB transfer type
  input  wire logic        hwrite,             // AHB write
  input  wire logic [2:0]  hsize,              // AHB size
  input  wire logic [31:0] hwdata,             // AHB write data
  input  wire logic        hready,             // AHB bus ready
  output logic      [31:0] hrdata,             // AHB read data
  output logic             hreadyout,          // AHB slave ready
  output logic             hresp,              // AHB response, always OKAY
  input  wire logic        cpu_idle,           // Processor in idle mode
  input  wire logic        token_busy,         // Token engine busy
  input  wire logic        line_drive,         // Datapath drives D+/D-
  input  wire logic        pin_id,             // OTG ID pin
  input  wire logic        pin_dp,             // D+ receiver
  input  wire logic        pin_dm,             // D- receiver
  input  wire logic        low_speed,          // Link runs at low speed
  input  wire logic        ext_vbus_valid_pin,     // External VBUS valid
  input  wire logic        ext_session_valid_pin,  // External session valid
  input  wire logic        ext_session_end_pin,    // External session end
  input  wire logic        comparator_status_one,  // Encoded comparator status bit 1
  input  wire logic        comparator_status_two,  // Encoded comparator status bit 2
  input  wire logic        int_vbus_valid,     // On-chip comparator VBUS valid
  input  wire logic        int_session_valid,  // On-chip comparator session valid
  input  wire logic        int_session_end,    // On-chip comparator session end
  output logic             token_start,        // One-cycle pulse: token issued
  output logic      [3:0]  token_type,         // Token type code
  output logic      [3:0]  target_endpoint,    // Token endpoint
  output logic             token_tx,           // Token transmits
  output logic      [7:0]  frame_threshold,    // Threshold count
  output logic             eye_test_enable,    // Eye pattern test on
  output logic             drive_oe_n,         // Active low drive monitor
  output logic             module_run,         // Module powered and not halted
  output logic      [1:0]  pingpong_config,    // Ping-pong mode
  output logic             comparator_pin_select,  // Three pin comparator mode
  output logic             vbus_pullup_enable, // VBUS pull-up on
  output logic             external_ctrl_via_i2c,  // I2C external control
  output logic             ext_supply_ctrl_en, // Digital supply control output on
  output logic             ext_cmp_input_en,   // Digital comparator input on
  output logic             ext_xcvr_en,        // External transceiver path on
  output logic             otg_irq             // OTG interrupt request
);

  // Bus side
  logic                          bus_take;
  logic                          wr_pend_reg;
  logic [11:0]                   addr_reg;
  logic                          rd_pend_reg;
  uotg_pkg::uotg_bus_state_type  bus_state;

  // Registers
  logic [7:0] token_reg;
  logic [7:0] thresh_reg;
  logic [7:0] cfg1_reg;
  logic [7:0] cfg2_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] flag_en_reg;
  logic       power_reg;
  logic       start_reg;

  // Pin synchronisers
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  logic [8:0] prev_reg;
  logic [1:0] warm_reg;
  logic       warm;

  // Timers and line state
  logic [16:0] ms_cnt_reg;
  logic [16:0] line_cnt_reg;
  logic [1:0]  line_stable_reg;
  logic [1:0]  line_seen_reg;

  assign bus_take  = hsel & hready & htrans[1];
  assign bus_state = wr_pend_reg ? uotg_pkg::BUS_WR : (rd_pend_reg ? uotg_pkg::BUS_RD : uotg_pkg::BUS_IDLE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 12'h000;
    end else begin
      wr_pend_reg <= bus_take & hwrite;
      rd_pend_reg <= bus_take & ~hwrite;
      addr_reg    <= bus_take ? haddr : addr_reg;
    end
  end

  // Write decode
  wire       wr_ok     = (bus_state == uotg_pkg::BUS_WR);
  wire [7:0] wbyte     = hwdata[7:0];
  wire       wr_token  = wr_ok & (addr_reg == `UOTG_OFS_TOKEN);
  wire       wr_thresh = wr_ok & (addr_reg == `UOTG_OFS_THRESH);
  wire       wr_cfg1   = wr_ok & (addr_reg == `UOTG_OFS_CFG1);
  wire       wr_cfg2   = wr_ok & (addr_reg == `UOTG_OFS_CFG2);
  wire       wr_flags  = wr_ok & (addr_reg == `UOTG_OFS_FLAGS);
  wire       wr_flagen = wr_ok & (addr_reg == `UOTG_OFS_FLAG_EN);
  wire       wr_power  = wr_ok & (addr_reg == `UOTG_OFS_POWER);
  wire [3:0] wr_type   = wbyte[`UOTG_TOK_TYPE_HI:`UOTG_TOK_TYPE_LO];
  wire       type_ok   = (wr_type == uotg_pkg::TOK_SETUP) | (wr_type == uotg_pkg::TOK_IN) |
                         (wr_type == uotg_pkg::TOK_OUT);
  wire       run_now   = power_reg & ~(cfg1_reg[`UOTG_CFG1_IDLE] & sync2_reg[0]);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      token_reg   <= `UOTG_RESET_BYTE;
      thresh_reg  <= `UOTG_RESET_BYTE;
      cfg1_reg    <= `UOTG_RESET_BYTE;
      cfg2_reg    <= `UOTG_RESET_BYTE;
      flag_en_reg <= `UOTG_RESET_BYTE;
      power_reg   <= 1'b0;
      start_reg   <= 1'b0;
    end else begin
      token_reg   <= wr_token ? wbyte : token_reg;
      thresh_reg  <= wr_thresh ? wbyte : thresh_reg;
      cfg1_reg    <= wr_cfg1 ? (wbyte & `UOTG_CFG1_MASK) : cfg1_reg; // R05
      cfg2_reg    <= wr_cfg2 ? (wbyte & `UOTG_CFG2_MASK) : cfg2_reg; // R05
      flag_en_reg <= wr_flagen ? (wbyte & `UOTG_FLAG_MASK) : flag_en_reg; // R26
      power_reg   <= wr_power ? wbyte[0] : power_reg; // R24
      start_reg   <= wr_token & type_ok & run_now & ~token_busy; // R01
    end
  end

  // Read mux decodes the address phase so data stands in the data phase; upper bits always zero
  logic [7:0] rd_byte;
  always_comb begin
    unique case (haddr)
      `UOTG_OFS_TOKEN:   rd_byte = token_reg;
      `UOTG_OFS_THRESH:  rd_byte = thresh_reg;
      `UOTG_OFS_CFG1:    rd_byte = cfg1_reg;
      `UOTG_OFS_CFG2:    rd_byte = cfg2_reg;
      `UOTG_OFS_FLAGS:   rd_byte = flags_reg;
      `UOTG_OFS_FLAG_EN: rd_byte = flag_en_reg;
      `UOTG_OFS_POWER:   rd_byte = {7'h00, power_reg};
      `UOTG_OFS_LIVE:    rd_byte = {line_seen_reg[0], line_seen_reg[1], 6'h00}; // R25
      default:           rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= (bus_take & ~hwrite) ? {24'h000000, rd_byte} : hrdata; // R05
    end
  end

  // Slave answers with zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Comparator source selection
  wire [1:0] enc_st = {comparator_status_two, comparator_status_one};
  wire       ext_vv = cfg2_reg[`UOTG_CFG2_CMPSEL] ? ext_vbus_valid_pin : (enc_st == 2'h3); // R11
  wire       ext_sv = cfg2_reg[`UOTG_CFG2_CMPSEL] ? ext_session_valid_pin : enc_st[1]; // R11
  wire       ext_se = cfg2_reg[`UOTG_CFG2_CMPSEL] ? ext_session_end_pin : (enc_st == 2'h0); // R11
  wire       vv_src = cfg2_reg[`UOTG_CFG2_CMPDIS] ? ext_vv : int_vbus_valid; // R15
  wire       sv_src = cfg2_reg[`UOTG_CFG2_CMPDIS] ? ext_sv : int_session_valid; // R15
  wire       se_src = cfg2_reg[`UOTG_CFG2_CMPDIS] ? ext_se : int_session_end; // R15

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 9'h000;
      sync2_reg <= 9'h000;
      prev_reg  <= 9'h000;
      warm_reg  <= 2'h0;
    end else begin
      warm_reg  <= (warm_reg == 2'h3) ? warm_reg : warm_reg + 2'h1;
      sync1_reg <= {low_speed, pin_id, pin_dp, pin_dm, vv_src, sv_src, se_src, line_drive, cpu_idle};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // No edges until the synchroniser pipe holds real pin levels, else reset fakes a change
  assign warm = (warm_reg == 2'h3);
  wire       id_edge   = warm & (sync2_reg[7] ^ prev_reg[7]);
  wire       dline_chg = warm & (|(sync2_reg[6:5] ^ prev_reg[6:5]));
  wire       vv_cross  = warm & (sync2_reg[4] ^ prev_reg[4]);
  wire       sv_cross  = warm & (sync2_reg[3] ^ prev_reg[3]);
  wire       se_cross  = warm & (sync2_reg[2] ^ prev_reg[2]);
  wire       se0_live  = ~sync2_reg[6] & ~sync2_reg[5];
  wire       j_live    = sync2_reg[8] ? (~sync2_reg[6] & sync2_reg[5]) : (sync2_reg[6] & ~sync2_reg[5]);
  wire [1:0] line_now  = {se0_live, j_live};
  wire       ms_tick   = (ms_cnt_reg == 17'(MS_CYCLES - 1));
  wire       line_done = (line_cnt_reg == 17'(MS_CYCLES - 1));
  wire       line_evt  = line_done & (line_now != line_stable_reg);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_reg      <= 17'h00000;
      line_cnt_reg    <= 17'h00000;
      line_stable_reg <= 2'h0;
      line_seen_reg   <= 2'h0;
    end else begin
      ms_cnt_reg      <= (ms_tick | ~run_now) ? 17'h00000 : ms_cnt_reg + 17'h00001; // R19
      line_seen_reg   <= line_now;
      line_cnt_reg    <= (line_now != line_seen_reg) ? 17'h00000 :
                         (line_done ? line_cnt_reg : line_cnt_reg + 17'h00001); // R20
      line_stable_reg <= line_done ? line_now : line_stable_reg; // R20
    end
  end

  // Event flags: set wins over write-one clear
  logic [7:0] flag_set;
  always_comb begin
    flag_set = 8'h00;
    flag_set[`UOTG_FLAG_ID]   = id_edge; // R18
    flag_set[`UOTG_FLAG_MS]   = ms_tick & run_now; // R19
    flag_set[`UOTG_FLAG_LINE] = line_evt & ~(line_cnt_reg == 17'h00000); // R20
    flag_set[`UOTG_FLAG_ACT]  = dline_chg | vv_cross | sv_cross | se_cross; // R21
    flag_set[`UOTG_FLAG_SESV] = sv_cross; // R22
    flag_set[`UOTG_FLAG_SEND] = se_cross; // R22
    flag_set[`UOTG_FLAG_VBUS] = vv_cross; // R22
    flags_next = ((flags_reg & ~(wr_flags ? wbyte : 8'h00)) | flag_set) & `UOTG_FLAG_MASK; // R23
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= `UOTG_RESET_BYTE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      token_start           <= 1'b0;
      token_type            <= 4'h0;
      target_endpoint       <= 4'h0;
      token_tx              <= 1'b0;
      frame_threshold       <= 8'h00;
      eye_test_enable       <= 1'b0;
      drive_oe_n            <= 1'b1;
      module_run            <= 1'b0;
      pingpong_config       <= 2'h0;
      comparator_pin_select <= 1'b0;
      vbus_pullup_enable    <= 1'b0;
      external_ctrl_via_i2c <= 1'b0;
      ext_supply_ctrl_en    <= 1'b0;
      ext_cmp_input_en      <= 1'b0;
      ext_xcvr_en           <= 1'b0;
      otg_irq               <= 1'b0;
    end else begin
      token_start           <= start_reg; // R01
      token_type            <= token_reg[`UOTG_TOK_TYPE_HI:`UOTG_TOK_TYPE_LO];
      target_endpoint       <= token_reg[`UOTG_TOK_EP_HI:`UOTG_TOK_EP_LO];
      token_tx              <= token_reg[`UOTG_TOK_TYPE_HI:`UOTG_TOK_TYPE_LO] != uotg_pkg::TOK_IN; // R01
      frame_threshold       <= thresh_reg; // R04
      eye_test_enable       <= cfg1_reg[`UOTG_CFG1_EYE]; // R06
      drive_oe_n            <= ~(cfg1_reg[`UOTG_CFG1_MON] & cfg2_reg[`UOTG_CFG2_XCVR] & sync2_reg[1]); // R07 R08
      module_run            <= power_reg & ~(cfg1_reg[`UOTG_CFG1_IDLE] & sync2_reg[0]); // R09 R24
      pingpong_config       <= cfg1_reg[1:0]; // R10
      comparator_pin_select <= cfg2_reg[`UOTG_CFG2_CMPSEL]; // R11
      vbus_pullup_enable    <= cfg2_reg[`UOTG_CFG2_PULLUP]; // R12
      external_ctrl_via_i2c <= cfg2_reg[`UOTG_CFG2_I2C]; // R13
      ext_supply_ctrl_en    <= cfg2_reg[`UOTG_CFG2_BOOST]; // R14
      ext_cmp_input_en      <= cfg2_reg[`UOTG_CFG2_CMPDIS]; // R15
      ext_xcvr_en           <= cfg2_reg[`UOTG_CFG2_XCVR]; // R16
      otg_irq               <= |(flags_next & flag_en_reg); // R27
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence tok_write_s;
    wr_token & type_ok & run_now & ~token_busy;
  endsequence

  token_pulse_a: assert property (tok_write_s |-> ##2 token_start ##1 !token_start) // R01
    else $error("token start pulse wrong");
  bad_type_a: assert property (wr_token & !type_ok |-> ##2 !token_start) // R01
    else $error("reserved token type started");
  upper_zero_a: assert property (rd_pend_reg |=> hrdata[31:8] == 24'h000000) // R05
    else $error("upper read bits not zero");
  monitor_gate_a: assert property (!cfg2_reg[`UOTG_CFG2_XCVR] |=> drive_oe_n) // R08
    else $error("monitor active without transceiver disable");
  pullup_follow_a: assert property ($changed(cfg2_reg[`UOTG_CFG2_PULLUP]) |=> vbus_pullup_enable == $past(cfg2_reg[4])) // R12
    else $error("pull-up does not follow bit");
  id_set_a: assert property (id_edge |=> flags_reg[`UOTG_FLAG_ID]) // R18
    else $error("id change flag not set");
  set_wins_a: assert property (wr_flags & wbyte[`UOTG_FLAG_ACT] & flag_set[4] |=> flags_reg[`UOTG_FLAG_ACT]) // R23
    else $error("activity event lost on clear");
  clear_one_a: assert property (wr_flags & (flag_set == 8'h00) |=> (flags_reg & $past(wbyte)) == 8'h00) // R23
    else $error("write one did not clear");
  irq_flag_a: assert property (otg_irq |-> $past(|(flags_next & flag_en_reg))) // R27
    else $error("irq without enabled flag");
  vbus_cross_a: assert property (vv_cross |=> flags_reg[`UOTG_FLAG_VBUS] & flags_reg[`UOTG_FLAG_ACT]) // R22
    else $error("vbus crossing flag missing");

endmodule : uotg_ctrl

// *** testbench/uotg_far_model.sv ***
// Far-side model: attached peripheral on D+/D-, ID pin and the VBUS comparators.
// Assumes the bench commands it on ref_clk; slow delays every pin by three cycles.
`timescale 1ns/1ns
module uotg_far_model (
  input  wire logic       ref_clk,                // System clock
  input  wire logic       slow,                   // Answer three cycles late
  input  wire logic       id_cmd,                 // ID pin level
  input  wire logic [1:0] attach_cmd,             // 0 none, 1 full speed, 2 low speed
  input  wire logic [1:0] vbus_cmd,               // 0 below session end, 1 session valid, 2 VBUS valid
  output logic            pin_id,                 // ID pin
  output logic            pin_dp,                 // D+ level
  output logic            pin_dm,                 // D- level
  output logic            low_speed,              // Peripheral is low speed
  output logic            ext_vbus_valid_pin,     // Separate VBUS valid
  output logic            ext_session_valid_pin,  // Separate session valid
  output logic            ext_session_end_pin,    // Separate session end
  output logic            comparator_status_one,  // Encoded status, high only at VBUS valid
  output logic            comparator_status_two,  // Encoded status, high from session valid
  output logic            int_vbus_valid,         // On-chip comparator outputs
  output logic            int_session_valid,      // On-chip comparator outputs
  output logic            int_session_end         // On-chip comparator outputs
);
  logic [4:0] stage_reg [0:2];
  logic [4:0] now;
  always_ff @(posedge ref_clk) begin
    stage_reg[0] <= {id_cmd, attach_cmd, vbus_cmd};
    stage_reg[1] <= stage_reg[0];
    stage_reg[2] <= stage_reg[1];
  end
  assign now = slow ? stage_reg[2] : {id_cmd, attach_cmd, vbus_cmd};
  // Detached lines fall to the host pull-downs
  assign pin_id = now[4];
  assign pin_dp = (now[3:2] == 2'h1);
  assign pin_dm = (now[3:2] == 2'h2);
  assign low_speed = (now[3:2] == 2'h2);
  assign int_vbus_valid = (now[1:0] == 2'h2);
  assign int_session_valid = (now[1:0] != 2'h0);
  assign int_session_end = (now[1:0] == 2'h0);
  assign ext_vbus_valid_pin = int_vbus_valid;
  assign ext_session_valid_pin = int_session_valid;
  assign ext_session_end_pin = int_session_end;
  assign comparator_status_one = int_vbus_valid;
  assign comparator_status_two = int_session_valid;
endmodule : uotg_far_model

// *** testbench/uotg_ctrl_tb.sv ***
// Self-checking bench for the OTG control slice, registers reached over AHB-Lite.
// Assumes uotg_ctrl and uotg_far_model compiled first; 1 ms shortened to MS cycles.
`timescale 1ns/1ns
module uotg_ctrl_tb;
  localparam int MS = 20;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, cpu_idle = 1'b0, token_busy = 1'b0, line_drive = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0, attach_cmd = 2'h0, vbus_cmd = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic        slow = 1'b0, id_cmd = 1'b0, hreadyout, hresp, token_start, token_tx, otg_irq;
  logic        pin_id, pin_dp, pin_dm, low_speed, ext_vbus_valid_pin, ext_session_valid_pin, ext_session_end_pin;
  logic        comparator_status_one, comparator_status_two, int_vbus_valid, int_session_valid, int_session_end;
  logic [3:0]  token_type, target_endpoint;
  logic [7:0]  frame_threshold;
  logic [1:0]  pingpong_config;
  logic        eye_test_enable, drive_oe_n, module_run, comparator_pin_select, vbus_pullup_enable;
  logic        external_ctrl_via_i2c, ext_supply_ctrl_en, ext_cmp_input_en, ext_xcvr_en;
  int          checks = 0, failures = 0;

  always #4 ref_clk = ~ref_clk;

  uotg_ctrl #(.MS_CYCLES(MS)) u_dut (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cpu_idle, .token_busy, .line_drive, .pin_id, .pin_dp,
    .pin_dm, .low_speed, .ext_vbus_valid_pin, .ext_session_valid_pin, .ext_session_end_pin,
    .comparator_status_one, .comparator_status_two, .int_vbus_valid, .int_session_valid, .int_session_end,
    .token_start, .token_type, .target_endpoint, .token_tx, .frame_threshold, .eye_test_enable, .drive_oe_n,
    .module_run, .pingpong_config, .comparator_pin_select, .vbus_pullup_enable, .external_ctrl_via_i2c,
    .ext_supply_ctrl_en, .ext_cmp_input_en, .ext_xcvr_en, .otg_irq);

  uotg_far_model u_far (.ref_clk, .slow, .id_cmd, .attach_cmd, .vbus_cmd, .pin_id, .pin_dp, .pin_dm,
    .low_speed, .ext_vbus_valid_pin, .ext_session_valid_pin, .ext_session_end_pin, .comparator_status_one,
    .comparator_status_two, .int_vbus_valid, .int_session_valid, .int_session_end);

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & mask, exp);
  endtask : rd_chk

  task automatic t_reset();
    logic [11:0] adr [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h014, 12'h018, 12'h040};
    for (int i = 0; i < 7; i++) rd_chk(adr[i], 32'hffff_ffff, 32'h0);
    check(32'({drive_oe_n, module_run, eye_test_enable, ext_xcvr_en, otg_irq}), 32'h10);
  endtask : t_reset

  task automatic t_token();
    logic [3:0] ty [5] = '{4'h1, 4'h9, 4'hd, 4'h5, 4'h1};
    int cnt;
    wr(12'h018, 32'h1);
    for (int i = 0; i < 5; i++) begin
      token_busy <= (i == 4);
      wr(12'h000, {24'hff_ffff, ty[i], 4'(i + 3)});
      cnt = 0;
      repeat (8) begin
        @(posedge ref_clk);
        if (token_start === 1'b1) cnt++;
      end
      check(32'(cnt), 32'(i < 3));
      check(32'({token_type, target_endpoint}), {24'h0, ty[i], 4'(i + 3)});
      if (i < 3) check(32'(token_tx), 32'(ty[i] != 4'h9));
      rd_chk(12'h000, 32'hffff_ffff, {24'h0, ty[i], 4'(i + 3)});
    end
    token_busy <= 1'b0;
  endtask : t_token

  task automatic t_thresh();
    int sz [3] = '{64, 32, 8};
    for (int i = 0; i < 3; i++) begin
      wr(12'h004, 32'hffff_ff00 | 32'(sz[i] + 10));
      idle(2);
      check(32'(frame_threshold), 32'(sz[i] + 10));
      rd_chk(12'h004, 32'hffff_ffff, 32'(sz[i] + 10));
    end
  endtask : t_thresh

  task automatic t_cfg1();
    wr(12'h008, 32'hffff_ffff);
    rd_chk(12'h008, 32'hffff_ffff, 32'hd3);
    check(32'(eye_test_enable), 32'h1);
    for (int p = 0; p < 4; p++) begin
      wr(12'h008, 32'(p));
      idle(2);
      check(32'({eye_test_enable, pingpong_config}), 32'(p));
    end
    wr(12'h008, 32'h10);
    cpu_idle <= 1'b1;
    idle(6);
    check(32'(module_run), 32'h0);
    cpu_idle <= 1'b0;
    idle(6);
    check(32'(module_run), 32'h1);
    wr(12'h008, 32'h0);
    cpu_idle <= 1'b1;
    idle(6);
    check(32'(module_run), 32'h1);
    cpu_idle <= 1'b0;
    wr(12'h018, 32'h0);
    idle(2);
    check(32'(module_run), 32'h0);
  endtask : t_cfg1

  task automatic t_cfg2();
    for (int b = 0; b < 6; b++) begin
      wr(12'h00c, 32'hffff_ff00 | (32'h1 << b));
      idle(2);
      check(32'({comparator_pin_select, vbus_pullup_enable, external_ctrl_via_i2c, ext_supply_ctrl_en,
        ext_cmp_input_en, ext_xcvr_en}), 32'h1 << b);
      rd_chk(12'h00c, 32'hffff_ffff, 32'h1 << b);
    end
    wr(12'h008, 32'h40);
    wr(12'h00c, 32'h0);
    line_drive <= 1'b1;
    idle(6);
    check(32'(drive_oe_n), 32'h1);
    wr(12'h00c, 32'h1);
    idle(6);
    check(32'(drive_oe_n), 32'h0);
    line_drive <= 1'b0;
    idle(6);
    check(32'(drive_oe_n), 32'h1);
    wr(12'h008, 32'h0);
    line_drive <= 1'b1;
    idle(6);
    check(32'(drive_oe_n), 32'h1);
    line_drive <= 1'b0;
    wr(12'h00c, 32'h0);
  endtask : t_cfg2

  task automatic t_flags();
    wr(12'h010, 32'hff);
    idle(4);
    rd_chk(12'h010, 32'h9d, 32'h0);
    vbus_cmd <= 2'h2;
    idle(8);
    rd_chk(12'h010, 32'h1d, 32'h1d);
    wr(12'h010, 32'hff);
    vbus_cmd <= 2'h0;
    idle(8);
    rd_chk(12'h010, 32'h0d, 32'h0d);
    id_cmd <= 1'b1;
    idle(8);
    rd_chk(12'h010, 32'h8d, 32'h8d);
    wr(12'h010, 32'h80);
    rd_chk(12'h010, 32'h8d, 32'h0d);
    wr(12'h014, 32'h80);
    idle(2);
    check(32'(otg_irq), 32'h0);
    id_cmd <= 1'b0;
    idle(8);
    check(32'(otg_irq), 32'h1);
    wr(12'h010, 32'h80);
    idle(3);
    check(32'(otg_irq), 32'h0);
    wr(12'h014, 32'h01);
    idle(2);
    check(32'(otg_irq), 32'h1);
    wr(12'h010, 32'hff);
    idle(3);
    check(32'(otg_irq), 32'h0);
    wr(12'h014, 32'h0);
  endtask : t_flags

  task automatic t_timer_line();
    wr(12'h018, 32'h1);
    wr(12'h010, 32'hff);
    idle(MS + 10);
    rd_chk(12'h010, 32'h40, 32'h40);
    slow <= 1'b1;
    attach_cmd <= 2'h1;
    idle(3 * MS);
    rd_chk(12'h010, 32'h30, 32'h30);
    rd_chk(12'h01c, 32'hc0, 32'h80);
    attach_cmd <= 2'h2;
    idle(8);
    rd_chk(12'h01c, 32'hc0, 32'h80);
    wr(12'h018, 32'h0);
    wr(12'h010, 32'hff);
    idle(3 * MS);
    rd_chk(12'h010, 32'h40, 32'h0);
  endtask : t_timer_line

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    idle(1);
    t_reset();
    t_token();
    t_thresh();
    t_cfg1();
    t_cfg2();
    t_flags();
    t_timer_line();
    end_of_test();
  end
endmodule : uotg_ctrl_tb
